// [pkg/sddc_pkg.sv]
package sddc_pkg;
  // bus geometry
  localparam int unsigned DATA_W = 32; // wishbone data width
  localparam int unsigned REG_W = 8; // every register is one byte wide
  localparam int unsigned IDX_W = 32; // decoded address width, the full byte address
  localparam int unsigned IDX_LSB = 0; // lowest decoded address bit

  // register byte addresses, one apart; every register sits on data lane zero
  localparam logic [IDX_W-1:0] IDX_ENABLE = 32'h0000_5100; // detect_enable
  localparam logic [IDX_W-1:0] IDX_LEVEL = 32'h0000_5101; // compare_level
  localparam logic [IDX_W-1:0] IDX_RESULT = 32'h0000_5102; // detect_result
  localparam logic [IDX_W-1:0] IDX_MASK = 32'h0000_5103; // drop_irq_mask
  localparam logic [IDX_W-1:0] IDX_FLAG = 32'h0000_5104; // drop_irq_flag

  // field positions
  localparam int unsigned BIT_ENABLE = 0; // detect_on
  localparam int unsigned BIT_RESULT = 0; // below_level
  localparam int unsigned BIT_MASK = 0; // drop_irq_on
  localparam int unsigned BIT_FLAG = 0; // drop_flag
  localparam int unsigned LEVEL_W = 4; // level_select width, bits 3..0
  localparam int unsigned SEL_LANE = 0; // byte lane holding the register

  // reset values
  localparam logic RESET_BIT = 1'h0; // single-bit controls and flags
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0; // compare level code
  localparam logic [REG_W-1:0] BYTE_ZERO = 8'h00; // empty byte
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000; // empty word

  // interrupt identity at the controller
  localparam logic [7:0] VECTOR_NUM = 8'h09; // vector number
  localparam logic [15:0] VECTOR_ADDR = 16'h8024; // vector address

  // comparator synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
endpackage

// [pkg/sddc_det_if.sv]
`timescale 1ns/1ps
// carries the comparator path between synchroniser, detector and control
interface sddc_det_if;
  logic below; // synchronised comparator, high while supply under level
  logic detect_on; // detection enabled by software
  logic drop; // one-cycle drop event
  modport sync_side (output below);
  modport det_side (input below, input detect_on, output drop);
  modport ctrl_side (input below, input drop, output detect_on);
endinterface

// [verilog/sddc_sync.sv]
`timescale 1ns/1ps
// two-flop synchroniser for the asynchronous comparator output
module sddc_sync #(
  parameter int unsigned STAGES = sddc_pkg::SYNC_STAGES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // comparator from the analog side
  input wire logic async_i,
  // synchronised result
  sddc_det_if.sync_side det
);
  typedef struct packed {
    logic [STAGES-1:0] chain; // shift chain, bit 0 is the first flop
  } sddc_sync_type;

  sddc_sync_type state; // registered state
  sddc_sync_type next_state; // next value

  // shift in the pin; only the next stage reads the first flop
  always_comb begin
    next_state = state;
    next_state.chain = {state.chain[STAGES-2:0], async_i};
  end

  // register, frozen while ce_i is low
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // last stage is the only consumer-visible bit
  assign det.below = state.chain[STAGES-1];
endmodule

// [verilog/sddc_drop_det.sv]
`timescale 1ns/1ps
// finds the not-low to low transition while detection is on
module sddc_drop_det (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // comparator path
  sddc_det_if.det_side det
);
  typedef struct packed {
    logic prev; // below level one cycle ago
  } sddc_det_type;

  sddc_det_type state; // registered state
  sddc_det_type next_state; // next value

  // remember the previous level every cycle, enabled or not
  always_comb begin
    next_state = state;
    next_state.prev = det.below;
  end

  // register, frozen while ce_i is low
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= '0;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // a level already low when enabled gives no event
  assign det.drop = det.below & ~state.prev & det.detect_on;

  // an event lasts one advancing cycle
  a_drop_one_cycle: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (det.drop && ce_i) |=> !det.drop)
    else $error("drop event held longer than one cycle");
endmodule

// [verilog/sddc_top.sv]
`timescale 1ns/1ps
module sddc_top (
  // clock, reset and clock enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog comparator side
  input wire logic cmp_low_i,
  output logic detect_on_o,
  output logic [3:0] level_select_o,
  // interrupt controller side
  output logic drop_irq_o,
  output logic [7:0] irq_vector_o,
  output logic [15:0] irq_vector_addr_o
);
  // all control state in one record
  typedef struct packed {
    logic detect_on; // detection enable
    logic [sddc_pkg::LEVEL_W-1:0] level_select; // compare level code
    logic drop_irq_on; // interrupt mask enable
    logic drop_flag; // sticky drop flag
    logic irq; // registered request
    logic ack; // bus acknowledge
    logic [sddc_pkg::REG_W-1:0] rdata; // read data byte
  } sddc_state_type;

  // reset image of the record
  localparam sddc_state_type STATE_RESET = '{
    detect_on: sddc_pkg::RESET_BIT,
    level_select: sddc_pkg::LEVEL_RESET,
    drop_irq_on: sddc_pkg::RESET_BIT,
    drop_flag: sddc_pkg::RESET_BIT,
    irq: sddc_pkg::RESET_BIT,
    ack: sddc_pkg::RESET_BIT,
    rdata: sddc_pkg::BYTE_ZERO
  };

  sddc_state_type state; // registered state
  sddc_state_type next_state; // next value

  // comparator path shared with the helpers
  sddc_det_if det ();

  // bus request decode
  logic [sddc_pkg::IDX_W-1:0] idx; // byte address of the access
  logic take; // request accepted this cycle
  logic wr_lane; // write reaching the register byte
  logic below_level; // result bit as software sees it
  logic clear_hit; // write of one to the flag
  logic [sddc_pkg::REG_W-1:0] rd_value; // byte to return

  // true when the access index names the given register
  function automatic logic hit(
    input logic [sddc_pkg::IDX_W-1:0] a,
    input logic [sddc_pkg::IDX_W-1:0] r
  );
    hit = (a == r);
  endfunction

  // one bit placed at its field position in a byte
  function automatic logic [sddc_pkg::REG_W-1:0] place(
    input logic b,
    input int unsigned pos
  );
    logic [sddc_pkg::REG_W-1:0] v;
    v = sddc_pkg::BYTE_ZERO;
    v[pos] = b;
    place = v;
  endfunction

  // synchronise the asynchronous comparator pin
  sddc_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .async_i(cmp_low_i),
    .det(det.sync_side)
  );

  // find drops on the synchronised level
  sddc_drop_det u_det (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .det(det.det_side)
  );

  // the detector only looks while software has detection on
  assign det.detect_on = state.detect_on;

  // address and strobe decode
  assign idx = wb_adr_i[31:sddc_pkg::IDX_LSB];
  assign take = wb_cyc_i & wb_stb_i & ~state.ack;
  assign wr_lane = take & wb_we_i & wb_sel_i[sddc_pkg::SEL_LANE];

  // a switched-off comparator reports normal supply
  assign below_level = det.below & state.detect_on;

  // write of one to the flag bit
  assign clear_hit = wr_lane & hit(idx, sddc_pkg::IDX_FLAG)
    & wb_dat_i[sddc_pkg::BIT_FLAG];

  // read multiplexer, reserved bits read zero
  always_comb begin
    rd_value = sddc_pkg::BYTE_ZERO;
    if (hit(idx, sddc_pkg::IDX_ENABLE)) begin
      // enable register
      rd_value = place(state.detect_on, sddc_pkg::BIT_ENABLE);
    end else if (hit(idx, sddc_pkg::IDX_LEVEL)) begin
      // level field in the low nibble
      rd_value[sddc_pkg::LEVEL_W-1:0] = state.level_select;
    end else if (hit(idx, sddc_pkg::IDX_RESULT)) begin
      // live comparison result
      rd_value = place(below_level, sddc_pkg::BIT_RESULT);
    end else if (hit(idx, sddc_pkg::IDX_MASK)) begin
      // interrupt mask
      rd_value = place(state.drop_irq_on, sddc_pkg::BIT_MASK);
    end else if (hit(idx, sddc_pkg::IDX_FLAG)) begin
      // sticky flag
      rd_value = place(state.drop_flag, sddc_pkg::BIT_FLAG);
    end
  end

  // next-state logic for registers, flag and bus handshake
  always_comb begin
    next_state = state;
    // acknowledge one cycle after the request, drop it the next
    next_state.ack = take;
    // read data latched with the acknowledge; unmapped reads give zero
    if (take && !wb_we_i) begin
      next_state.rdata = rd_value;
    end
    // register writes through byte lane zero
    if (wr_lane) begin
      if (hit(idx, sddc_pkg::IDX_ENABLE)) begin
        // start or stop detection
        next_state.detect_on = wb_dat_i[sddc_pkg::BIT_ENABLE];
      end
      if (hit(idx, sddc_pkg::IDX_LEVEL)) begin
        // reserved codes are stored as written
        next_state.level_select = wb_dat_i[sddc_pkg::LEVEL_W-1:0];
      end
      if (hit(idx, sddc_pkg::IDX_MASK)) begin
        // mask enable; a low supply alone raises nothing
        next_state.drop_irq_on = wb_dat_i[sddc_pkg::BIT_MASK];
      end
    end
    // software clear, zero writes leave the flag alone
    if (clear_hit) begin
      next_state.drop_flag = 1'b0;
    end
    // a new drop wins over a clear in the same cycle
    if (det.drop) begin
      next_state.drop_flag = 1'b1;
    end
    // level request follows flag and mask exactly
    next_state.irq = next_state.drop_flag & next_state.drop_irq_on;
  end

  // register the record, frozen while ce_i is low
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= STATE_RESET;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // bus outputs
  assign wb_ack_o = state.ack;
  assign wb_dat_o = {{(sddc_pkg::DATA_W - sddc_pkg::REG_W){1'b0}}, state.rdata};

  // analog controls
  assign detect_on_o = state.detect_on;
  assign level_select_o = state.level_select;

  // interrupt request and its fixed vector
  assign drop_irq_o = state.irq;
  assign irq_vector_o = sddc_pkg::VECTOR_NUM;
  assign irq_vector_addr_o = sddc_pkg::VECTOR_ADDR;

  // checks below share one clock and reset
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // an enable write lands in the control bit
  a_enable_write: assert property (
    (ce_i && wr_lane && hit(idx, sddc_pkg::IDX_ENABLE))
    |=> (detect_on_o == $past(wb_dat_i[sddc_pkg::BIT_ENABLE])))
    else $error("enable write not taken");

  // result read returns the gated comparator level
  a_result_read: assert property (
    (ce_i && take && !wb_we_i && hit(idx, sddc_pkg::IDX_RESULT))
    |=> (wb_ack_o && wb_dat_o[sddc_pkg::BIT_RESULT] == $past(below_level)))
    else $error("result read mismatch");

  // a drop sets the flag on the next edge
  a_flag_set: assert property (
    (ce_i && det.drop) |=> state.drop_flag)
    else $error("drop did not set flag");

  // flag holds without a clear
  a_flag_sticky: assert property (
    (state.drop_flag && !(ce_i && clear_hit)) |=> state.drop_flag)
    else $error("flag lost without clear");

  // a clear without a drop empties the flag
  a_flag_clear: assert property (
    (ce_i && clear_hit && !det.drop) |=> !state.drop_flag)
    else $error("flag not cleared");

  // request equals flag and mask
  a_irq_level: assert property (
    drop_irq_o == (state.drop_flag && state.drop_irq_on))
    else $error("request not tied to flag and mask");

  // request stays up while flag and mask stay up
  a_irq_holds: assert property (
    (drop_irq_o && !(ce_i && clear_hit) && !(ce_i && wr_lane))
    |=> drop_irq_o)
    else $error("request dropped before clear");

  // unmasking with an empty flag raises nothing
  a_no_stale_irq: assert property (
    ($rose(state.drop_irq_on) && !state.drop_flag) |-> !drop_irq_o)
    else $error("spurious request on unmask");

  // upper bytes of the data bus read zero
  a_reserved_zero: assert property (
    wb_ack_o |-> (wb_dat_o[sddc_pkg::DATA_W-1:sddc_pkg::REG_W] == '0))
    else $error("reserved bits not zero");

  // acknowledge lasts exactly one cycle
  a_ack_pulse: assert property (
    (wb_ack_o && ce_i) |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  // level code survives reads and other writes
  a_level_hold: assert property (
    !(ce_i && wr_lane && hit(idx, sddc_pkg::IDX_LEVEL))
    |=> $stable(level_select_o))
    else $error("level changed without write");

  // a level write lands in the code field
  a_level_write: assert property (
    (ce_i && wr_lane && hit(idx, sddc_pkg::IDX_LEVEL))
    |=> (level_select_o == $past(wb_dat_i[sddc_pkg::LEVEL_W-1:0])))
    else $error("level write not taken");

  // a mask write lands in the mask bit
  a_mask_write: assert property (
    (ce_i && wr_lane && hit(idx, sddc_pkg::IDX_MASK))
    |=> (state.drop_irq_on == $past(wb_dat_i[sddc_pkg::BIT_MASK])))
    else $error("mask write not taken");

  // every accepted request is answered on the next edge
  a_ack_answer: assert property (
    (ce_i && take) |=> wb_ack_o)
    else $error("request not acknowledged");

  // no acknowledge without a request the cycle before
  a_ack_cause: assert property (
    (ce_i && !take) |=> !wb_ack_o)
    else $error("acknowledge without request");

  // detection off lets no drop event through
  a_drop_needs_on: assert property (
    det.drop |-> state.detect_on)
    else $error("drop seen with detection off");

  // with detection off an empty flag stays empty
  a_off_no_flag: assert property (
    (!state.detect_on && !state.drop_flag) |=> !state.drop_flag)
    else $error("flag set with detection off");

  // a zero written to the flag leaves it set
  a_zero_write_keeps: assert property (
    (ce_i && wr_lane && hit(idx, sddc_pkg::IDX_FLAG)
      && !wb_dat_i[sddc_pkg::BIT_FLAG] && state.drop_flag)
    |=> state.drop_flag)
    else $error("zero write cleared the flag");

  // a drop and a clear together leave the flag set
  a_set_beats_clear: assert property (
    (ce_i && det.drop && clear_hit) |=> state.drop_flag)
    else $error("clear beat a new drop");

  // a masked flag never requests
  a_mask_blocks: assert property (
    !state.drop_irq_on |-> !drop_irq_o)
    else $error("request while masked");

  // the flag falls only after a clear write
  a_flag_fall_cause: assert property (
    $fell(state.drop_flag) |-> ($past(ce_i) && $past(clear_hit)))
    else $error("flag fell without clear");

  // the request rises only with flag and mask both set
  a_irq_rise_cause: assert property (
    $rose(drop_irq_o) |-> (state.drop_flag && state.drop_irq_on))
    else $error("request rose without cause");

  // enable read returns the enable bit alone
  a_enable_read: assert property (
    (ce_i && take && !wb_we_i && hit(idx, sddc_pkg::IDX_ENABLE))
    |=> (wb_dat_o[sddc_pkg::REG_W-1:0]
      == place($past(state.detect_on), sddc_pkg::BIT_ENABLE)))
    else $error("enable read mismatch");

  // the interrupt identity never moves
  a_vector_fixed: assert property (
    (irq_vector_o == sddc_pkg::VECTOR_NUM)
      && (irq_vector_addr_o == sddc_pkg::VECTOR_ADDR))
    else $error("interrupt vector changed");

  // result reads zero while detection is off
  a_result_off: assert property (
    (ce_i && take && !wb_we_i && hit(idx, sddc_pkg::IDX_RESULT) && !state.detect_on)
    |=> (wb_dat_o == sddc_pkg::WORD_ZERO))
    else $error("result not zero while off");
endmodule

// [verif/sddc_irqc_model.sv]
`timescale 1ns/1ps
// behavioural interrupt controller input stage, level triggered
module sddc_irqc_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // request and identity from the block
  input wire logic irq_i,
  input wire logic [7:0] vector_i,
  // controller side flag and vector captured on request
  output logic flag_o,
  output logic [7:0] vector_o
);
  // flag follows the request level, so a cleared source clears it too
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
      vector_o <= 8'h00;
    end else begin
      flag_o <= irq_i;
      if (irq_i) begin
        vector_o <= vector_i;
      end
    end
  end
endmodule

// [verif/test_supply_drop_detect_ctrl.sv]
`timescale 1ns/1ps
// register level bench for the supply drop detector control
module test_supply_drop_detect_ctrl;
  // byte addresses of the five registers and one unmapped slot
  localparam logic [31:0] A_EN = 32'h0000_5100;
  localparam logic [31:0] A_LV = 32'h0000_5101;
  localparam logic [31:0] A_RS = 32'h0000_5102;
  localparam logic [31:0] A_MK = 32'h0000_5103;
  localparam logic [31:0] A_FL = 32'h0000_5104;
  localparam logic [31:0] A_UN = 32'h0000_5105;
  // stimulus and observed signals
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic cmp_low = 1'b0;
  logic ce = 1'b1;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic detect_on_o;
  logic [3:0] level_select_o;
  logic drop_irq_o;
  logic [7:0] irq_vector_o;
  logic [15:0] irq_vector_addr_o;
  logic ctrl_flag;
  logic [7:0] ctrl_vector;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] c;

  // 100 MHz clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // design under test
  sddc_top DUT (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cmp_low_i(cmp_low), .detect_on_o(detect_on_o), .level_select_o(level_select_o),
    .drop_irq_o(drop_irq_o), .irq_vector_o(irq_vector_o),
    .irq_vector_addr_o(irq_vector_addr_o)
  );

  // far side interrupt controller
  sddc_irqc_model irqc (
    .clock_i(clock_i), .rst_i(rst_i), .irq_i(drop_irq_o), .vector_i(irq_vector_o),
    .flag_o(ctrl_flag), .vector_o(ctrl_vector)
  );

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  // compare read data
  task automatic check_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // compare a port value
  task automatic check_pin(input string n, input logic [15:0] g, input logic [15:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb_cycle(input logic w, input logic [31:0] a, input logic [3:0] s,
                          input logic [31:0] d, output logic [31:0] r);
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // byte write on lane zero
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb_cycle(1'b1, a, 4'hF, {24'h00_0000, d}, r);
  endtask

  // byte read compared against the whole word
  task automatic rd(input string n, input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    wb_cycle(1'b0, a, 4'hF, 32'h0000_0000, r);
    check_reg(n, {24'h00_0000, e}, r);
  endtask

  // move the comparator and let it pass the synchroniser and the flag
  task automatic set_cmp(input logic v);
    @(posedge clock_i);
    cmp_low <= v;
    repeat (4) @(posedge clock_i);
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rd("enable", A_EN, 8'h00);
    rd("level", A_LV, 8'h00);
    rd("result", A_RS, 8'h00);
    rd("mask", A_MK, 8'h00);
    rd("flag", A_FL, 8'h00);
    rd("unmapped", A_UN, 8'h00);
    check_pin("vector", {8'h00, irq_vector_o}, 16'h0009);
    check_pin("vector address", irq_vector_addr_o, 16'h8024);
    // reserved bits read back zero, lane zero deselected is ignored
    wr(A_LV, 8'hA5);
    rd("level", A_LV, 8'h05);
    wb_cycle(1'b1, A_LV, 4'hE, 32'h0000_0007, r);
    rd("level", A_LV, 8'h05);
    check_pin("level pins", {12'h000, level_select_o}, 16'h0005);
    for (c = 8'h03; c < 8'h10; c = c + 8'h01) begin
      wr(A_LV, c);
      rd("level", A_LV, c);
    end
    // supply already low when detection starts
    set_cmp(1'b1);
    wr(A_EN, 8'hFF);
    rd("enable", A_EN, 8'h01);
    check_pin("detect on", {15'h0000, detect_on_o}, 16'h0001);
    rd("result", A_RS, 8'h01);
    rd("flag", A_FL, 8'h00);
    set_cmp(1'b0);
    rd("result", A_RS, 8'h00);
    wr(A_FL, 8'h01);
    wr(A_MK, 8'h01);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0000);
    // fresh drop raises a sticky flag and a level request
    set_cmp(1'b1);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0001);
    rd("flag", A_FL, 8'h01);
    check_pin("ctrl flag", {15'h0000, ctrl_flag}, 16'h0001);
    check_pin("ctrl vector", {8'h00, ctrl_vector}, 16'h0009);
    set_cmp(1'b0);
    rd("flag", A_FL, 8'h01);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0001);
    wr(A_FL, 8'h00);
    rd("flag", A_FL, 8'h01);
    wr(A_FL, 8'h01);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0000);
    rd("flag", A_FL, 8'h00);
    check_pin("ctrl flag", {15'h0000, ctrl_flag}, 16'h0000);
    // masked drop sets the flag only, unmasking then requests
    wr(A_MK, 8'h00);
    set_cmp(1'b1);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0000);
    rd("flag", A_FL, 8'h01);
    wr(A_MK, 8'h01);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0001);
    set_cmp(1'b0);
    wr(A_FL, 8'h01);
    // detection off ignores drops and reads no result
    wr(A_EN, 8'h00);
    check_pin("detect on", {15'h0000, detect_on_o}, 16'h0000);
    set_cmp(1'b1);
    rd("flag", A_FL, 8'h00);
    rd("result", A_RS, 8'h00);
    set_cmp(1'b0);
    // a low clock enable holds a drop back until it returns
    wr(A_EN, 8'h01);
    @(posedge clock_i);
    ce <= 1'b0;
    set_cmp(1'b1);
    check_pin("irq frozen", {15'h0000, drop_irq_o}, 16'h0000);
    ce <= 1'b1;
    repeat (4) @(posedge clock_i);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0001);
    set_cmp(1'b0);
    // reset in mid-run clears enable, flag, mask and request
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    rd("enable", A_EN, 8'h00);
    check_pin("irq", {15'h0000, drop_irq_o}, 16'h0000);
    rd("flag", A_FL, 8'h00);
    rd("mask", A_MK, 8'h00);
    wrap_up();
  end
endmodule
